/* ledr_router.sv */
`default_nettype none


module ledr_router #(
  parameter int unsigned WINK_CYC = ledr_pkg::WINK_CYCLES,
  parameter int unsigned SEL_BITS = ledr_pkg::SEL_W
) (
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  input  wire ledr_pkg::ledr_audio_s                 audio_ev,
  input  wire ledr_pkg::ledr_task_s                  task_busy,
  input  wire ledr_pkg::ledr_gen_s                   gen_in,
  input  wire logic                                  reduced_rate_mode,
  input  wire logic                                  peak_latch_clr,
  input  wire logic [ledr_pkg::NUM_LED-1:0]          sel_wr_en,
  input  wire logic [SEL_BITS-1:0]                   sel_wr_data,
  output var  logic [ledr_pkg::NUM_LED-1:0]          led
);

  localparam int unsigned CNT_W = $clog2(WINK_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WINK_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  if (WINK_CYC < 1) begin : g_bad_wink
    $error("wink length must be at least one cycle");
  end
  if (SEL_BITS < ledr_pkg::SEL_W) begin : g_bad_sel
    $error("selector too narrow for the source map");
  end

  // bounds-checked pick, shared by every LED
  function automatic logic pick_src(input logic [ledr_pkg::NUM_SRC-1:0] v, input logic [SEL_BITS-1:0] s);
    logic r;
    r = 1'b0;
    if (s < SEL_BITS'(ledr_pkg::NUM_SRC)) begin
      r = v[s];
    end
    return r;
  endfunction

  // ---------------- dynamic sources and their wink stretchers
  wire logic [ledr_pkg::NUM_AUDIO-1:0] audio_vec = audio_ev;
  wire logic any_peak_ev = audio_ev.aud_tx.peak | audio_ev.aud_rx.peak | audio_ev.pcm_tx.peak
                         | audio_ev.pcm_rx.peak | audio_ev.voc_tx.peak | audio_ev.voc_rx.peak
                         | audio_ev.ton_rx.peak | audio_ev.com_tx.peak | audio_ev.com_rx.peak;
  wire logic any_act_ev  = audio_ev.aud_tx.act | audio_ev.aud_rx.act | audio_ev.pcm_tx.act
                         | audio_ev.pcm_rx.act | audio_ev.voc_tx.act | audio_ev.voc_rx.act
                         | audio_ev.ton_rx.act | audio_ev.com_tx.act | audio_ev.com_rx.act;

  // order: audio[17:0], any peak, any act, late enc, late dec, err event
  wire logic [ledr_pkg::NUM_DYN-1:0] dyn_ev = {gen_in.err_ev, gen_in.late_dec_ev, gen_in.late_enc_ev,
                                               any_act_ev, any_peak_ev, audio_vec};
  logic [ledr_pkg::NUM_DYN-1:0] wink;

  // a fresh event restarts the wink so bursts keep the LED lit
  for (genvar d = 0; d < ledr_pkg::NUM_DYN; d++) begin : g_wink
    logic [CNT_W-1:0] cnt;
    wire logic [CNT_W-1:0] next_cnt = dyn_ev[d] ? CNT_LOAD
                                    : (cnt != CNT_ZERO) ? cnt - 1'b1 : CNT_ZERO;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cnt <= CNT_ZERO;
      else       cnt <= next_cnt;
    end
    assign wink[d] = (cnt != CNT_ZERO);
  end

  // ---------------- latched any-peak, set wins over clear
  logic peak_latched;
  wire logic next_peak_latched = any_peak_ev | (peak_latched & ~peak_latch_clr);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) peak_latched <= 1'b0;
    else       peak_latched <= next_peak_latched;
  end

  // ---------------- source vector
  logic [ledr_pkg::NUM_SRC-1:0] src;
  always_comb begin
    src = '0;
    src[ledr_pkg::SRC_OFF]          = 1'b0;
    src[ledr_pkg::SRC_ON]           = 1'b1;
    src[ledr_pkg::SRC_TASK_BASE +: ledr_pkg::NUM_TASK] = task_busy;
    src[ledr_pkg::SRC_REDUCED_RATE] = reduced_rate_mode;
    src[ledr_pkg::SRC_LATE_ENC]     = wink[20];
    src[ledr_pkg::SRC_LATE_DEC]     = wink[21];
    src[ledr_pkg::SRC_SPARE]        = 1'b0;
    src[ledr_pkg::SRC_AUDIO_BASE +: ledr_pkg::NUM_AUDIO] = wink[ledr_pkg::NUM_AUDIO-1:0];
    src[ledr_pkg::SRC_PEAK_LATCHED] = peak_latched;
    src[ledr_pkg::SRC_ANY_PEAK]     = wink[18];
    src[ledr_pkg::SRC_ANY_ACT]      = wink[19];
    src[ledr_pkg::SRC_VAD]          = gen_in.vad_level;
    src[ledr_pkg::SRC_RUN]          = gen_in.run_level;
    src[ledr_pkg::SRC_ERR]          = gen_in.err_level | wink[22];
  end

  // ---------------- selectors and LED flops
  logic [SEL_BITS-1:0] sel [ledr_pkg::NUM_LED];

  for (genvar i = 0; i < ledr_pkg::NUM_LED; i++) begin : g_led
    localparam logic [SEL_BITS-1:0] SEL_RST = (i == 0) ? SEL_BITS'(ledr_pkg::SEL_RST_FIRST)
                                            : (i == 1) ? SEL_BITS'(ledr_pkg::SEL_RST_SECOND)
                                            : SEL_BITS'(ledr_pkg::SEL_RST_OTHER);
    wire logic [SEL_BITS-1:0] next_sel = sel_wr_en[i] ? sel_wr_data : sel[i];
    wire logic next_led = pick_src(src, sel[i]);

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sel[i] <= SEL_RST;
        led[i] <= 1'b0;
      end else begin
        sel[i] <= next_sel;
        led[i] <= next_led;
      end
    end

    property p_off_dark;
      @(posedge clk) disable iff (!nrst)
        sel[i] == SEL_BITS'(ledr_pkg::SRC_OFF) |=> !led[i];
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("off selection lit an led");

    property p_on_lit;
      @(posedge clk) disable iff (!nrst)
        sel[i] == SEL_BITS'(ledr_pkg::SRC_ON) |=> led[i];
    endproperty
    a_on_lit: assert property (p_on_lit) else $error("on selection left an led dark");

    property p_range_dark;
      @(posedge clk) disable iff (!nrst)
        sel[i] >= SEL_BITS'(ledr_pkg::NUM_SRC) |=> !led[i];
    endproperty
    a_range_dark: assert property (p_range_dark) else $error("out of range selection lit an led");

    property p_sel_write;
      @(posedge clk) disable iff (!nrst)
        sel_wr_en[i] |=> sel[i] == $past(sel_wr_data);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector write not taken next clock");

    property p_reduced_follow;
      @(posedge clk) disable iff (!nrst)
        sel[i] == SEL_BITS'(ledr_pkg::SRC_REDUCED_RATE) |=> led[i] == $past(reduced_rate_mode);
    endproperty
    a_reduced_follow: assert property (p_reduced_follow) else $error("led does not follow reduced rate mode");

    property p_task_follow;
      @(posedge clk) disable iff (!nrst)
        sel[i] == SEL_BITS'(ledr_pkg::SRC_TASK_BASE) |=> led[i] == $past(task_busy.audio_hw_irq_ind);
    endproperty
    a_task_follow: assert property (p_task_follow) else $error("led does not follow task activity");

    property p_any_peak_wink;
      @(posedge clk) disable iff (!nrst)
        (any_peak_ev && sel[i] == SEL_BITS'(ledr_pkg::SRC_ANY_PEAK) && !sel_wr_en[i]) |-> ##2 led[i];
    endproperty
    a_any_peak_wink: assert property (p_any_peak_wink) else $error("any peak event did not light led");

    property p_any_act_wink;
      @(posedge clk) disable iff (!nrst)
        (audio_ev.ton_rx.act && sel[i] == SEL_BITS'(ledr_pkg::SRC_ANY_ACT) && !sel_wr_en[i]) |-> ##2 led[i];
    endproperty
    a_any_act_wink: assert property (p_any_act_wink) else $error("activity event did not light led");
  end

  // reset values of the first two selectors
  property p_reset_defaults;
    @(posedge clk) $rose(nrst) |-> sel[0] == SEL_BITS'(ledr_pkg::SEL_RST_FIRST)
                                && sel[1] == SEL_BITS'(ledr_pkg::SEL_RST_SECOND);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("wrong default led assignment");

  // every event reloads the full wink count, so a burst keeps the led lit
  property p_wink_len;
    @(posedge clk) disable iff (!nrst)
      any_peak_ev |=> g_wink[18].cnt == CNT_LOAD;
  endproperty
  a_wink_len: assert property (p_wink_len) else $error("wink counter not reloaded on event");

  property p_wink_end;
    @(posedge clk) disable iff (!nrst)
      (g_wink[18].cnt == CNT_W'(1) && !any_peak_ev) |=> !wink[18];
  endproperty
  a_wink_end: assert property (p_wink_end) else $error("wink did not end after its count");

endmodule // ledr_router

`default_nettype wire

/* ledr_pkg.sv */
`default_nettype none

package ledr_pkg;

  localparam int unsigned NUM_SRC       = 40;
  localparam int unsigned NUM_LED       = 6;
  localparam int unsigned SEL_W         = 6;
  localparam int unsigned NUM_TASK      = 10;
  localparam int unsigned NUM_AUDIO     = 18;
  localparam int unsigned NUM_DYN       = 23;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned WINK_TIME_MS  = 100;
  localparam int unsigned WINK_CYCLES   = WINK_TIME_MS * (CLK_HZ / 1000);

  // source index map, shared by selectors and the source vector
  localparam logic [SEL_W-1:0] SRC_OFF          = 6'h00;
  localparam logic [SEL_W-1:0] SRC_ON           = 6'h01;
  localparam logic [SEL_W-1:0] SRC_TASK_BASE    = 6'h02;
  localparam logic [SEL_W-1:0] SRC_REDUCED_RATE = 6'h0c;
  localparam logic [SEL_W-1:0] SRC_LATE_ENC     = 6'h0d;
  localparam logic [SEL_W-1:0] SRC_LATE_DEC     = 6'h0e;
  localparam logic [SEL_W-1:0] SRC_SPARE        = 6'h0f;
  localparam logic [SEL_W-1:0] SRC_AUDIO_BASE   = 6'h10;
  localparam logic [SEL_W-1:0] SRC_PEAK_LATCHED = 6'h22;
  localparam logic [SEL_W-1:0] SRC_ANY_PEAK     = 6'h23;
  localparam logic [SEL_W-1:0] SRC_ANY_ACT      = 6'h24;
  localparam logic [SEL_W-1:0] SRC_VAD          = 6'h25;
  localparam logic [SEL_W-1:0] SRC_RUN          = 6'h26;
  localparam logic [SEL_W-1:0] SRC_ERR          = 6'h27;

  localparam logic [SEL_W-1:0] SEL_RST_FIRST    = SRC_ANY_PEAK;
  localparam logic [SEL_W-1:0] SEL_RST_SECOND   = SRC_ANY_ACT;
  localparam logic [SEL_W-1:0] SEL_RST_OTHER    = SRC_OFF;

  // one detector pair; peak sits in the lower bit
  typedef struct packed {
    logic act;
    logic peak;
  } ledr_det_s;

  // mixer-referenced: tx = mixer output port, rx = mixer input port
  // declared high to low so aud_tx lands on the lowest audio index
  typedef struct packed {
    ledr_det_s ton_rx;
    ledr_det_s com_rx;
    ledr_det_s com_tx;
    ledr_det_s voc_rx;
    ledr_det_s voc_tx;
    ledr_det_s pcm_rx;
    ledr_det_s pcm_tx;
    ledr_det_s aud_rx;
    ledr_det_s aud_tx;
  } ledr_audio_s;

  // bit 0 audio hw irq .. bit 9 uart poll task
  typedef struct packed {
    logic uart_poll_task_ind;
    logic packet_router_task_ind;
    logic decoder_task_ind;
    logic encoder_task_ind;
    logic linear_voice_task_ind;
    logic rate_adapter_task_ind;
    logic nibble_rx_irq_ind;
    logic nibble_tx_irq_ind;
    logic sample_port_hw_irq_ind;
    logic audio_hw_irq_ind;
  } ledr_task_s;

  typedef struct packed {
    logic late_enc_ev;
    logic late_dec_ev;
    logic vad_level;
    logic run_level;
    logic err_level;
    logic err_ev;
  } ledr_gen_s;

endpackage : ledr_pkg

`default_nettype wire

/* test_ledr_router.sv */
`default_nettype none

module test_ledr_router;
  timeunit 1ns;
  timeprecision 1ps;

  // short wink keeps both edges of every pulse inside the run
  localparam int W = 8;

  logic                  clk;
  logic                  nrst;
  ledr_pkg::ledr_audio_s audio_ev;
  ledr_pkg::ledr_task_s  task_busy;
  ledr_pkg::ledr_gen_s   gen_in;
  logic                  reduced_rate_mode;
  logic                  peak_latch_clr;
  logic [5:0]            sel_wr_en;
  logic [5:0]            sel_wr_data;
  logic [5:0]            led;
  logic [5:0]            exp_led;
  logic [39:0]           src;
  logic [22:0]           ev;
  int                    sel[6];
  int                    cnt[23];
  bit                    lat;
  int                    mismatches;
  int                    checks;
  int                    v;

  ledr_router #(.WINK_CYC(W), .SEL_BITS(6)) DUT (
    .clk               (clk),
    .nrst              (nrst),
    .audio_ev          (audio_ev),
    .task_busy         (task_busy),
    .gen_in            (gen_in),
    .reduced_rate_mode (reduced_rate_mode),
    .peak_latch_clr    (peak_latch_clr),
    .sel_wr_en         (sel_wr_en),
    .sel_wr_data       (sel_wr_data),
    .led               (led)
  );

  always #2.5 clk = ~clk;

  // reference model: led follows last cycle's selector and sampled sources
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel = '{35, 36, 0, 0, 0, 0};
      cnt = '{default: 0};
      lat = 1'b0;
      exp_led = '0;
    end else begin
      ev = {gen_in.err_ev, |(audio_ev & 18'h2aaaa), |(audio_ev & 18'h15555),
            gen_in.late_dec_ev, gen_in.late_enc_ev, audio_ev};
      src = '0;
      src[1] = 1'b1;
      src[11:2] = task_busy;
      src[12] = reduced_rate_mode;
      src[13] = (cnt[18] != 0);
      src[14] = (cnt[19] != 0);
      for (int j = 0; j < 18; j++) src[16+j] = (cnt[j] != 0);
      src[34] = lat;
      src[35] = (cnt[20] != 0);
      src[36] = (cnt[21] != 0);
      src[37] = gen_in.vad_level;
      src[38] = gen_in.run_level;
      src[39] = gen_in.err_level | (cnt[22] != 0);
      for (int i = 0; i < 6; i++) exp_led[i] = (sel[i] < 40) ? src[sel[i]] : 1'b0;
      for (int j = 0; j < 23; j++) cnt[j] = ev[j] ? W : ((cnt[j] > 0) ? cnt[j] - 1 : 0);
      lat = ev[20] ? 1'b1 : (peak_latch_clr ? 1'b0 : lat);
      for (int i = 0; i < 6; i++) if (sel_wr_en[i]) sel[i] = sel_wr_data;
    end
  end

  task automatic check_led(input logic [5:0] exp);
    checks++;
    if (led !== exp) begin
      mismatches++;
      $display("Error at %0t: led %b expected %b", $time, led, exp);
    end
  endtask

  // settled mid-cycle, away from the edge that updates led
  always @(negedge clk) check_led(exp_led);

  // events are sparse so winks can run out; levels toggle freely
  task automatic step(input logic [5:0] m, input logic [5:0] d);
    @(posedge clk);
    audio_ev          <= ($urandom % 6 == 0) ? ledr_pkg::ledr_audio_s'(18'($urandom)) : '0;
    task_busy         <= ledr_pkg::ledr_task_s'(10'($urandom));
    gen_in            <= ledr_pkg::ledr_gen_s'(6'($urandom) & (($urandom % 5 == 0) ? 6'h3f : 6'h0e));
    reduced_rate_mode <= ($urandom % 4 == 0) ? ~reduced_rate_mode : reduced_rate_mode;
    peak_latch_clr    <= ($urandom % 16 == 0);
    sel_wr_en         <= m;
    sel_wr_data       <= d;
  endtask

  task automatic run(input int n);
    repeat (n) step('0, 6'($urandom));
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    report_and_stop;
  end

  initial begin
    void'($urandom(14));
    clk = 1'b0;
    nrst = 1'b0;
    audio_ev = '0;
    task_busy = '0;
    gen_in = '0;
    reduced_rate_mode = 1'b0;
    peak_latch_clr = 1'b0;
    sel_wr_en = '0;
    sel_wr_data = '0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    run(60);
    // every selector code, including out-of-range ones, written once to one LED, rotating through the LEDs
    for (v = 0; v < 64; v++) begin
      step(6'h01 << (v % 6), 6'(v));
      run(10);
    end
    // back-to-back and multi-LED writes sharing one data value
    for (v = 0; v < 200; v++) step(6'($urandom), 6'($urandom));
    run(20);
    // second reset must bring back the default pair
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    run(60);
    report_and_stop;
  end
endmodule // test_ledr_router

`default_nettype wire
